// *** core/hsfc_fault_ctrl.sv ***
// protection and fault handling controller of a single channel high side switch
`timescale 1ns/1ps
`include "hsfc_regs.svh"

// What this block does
// - thermal or current fault forces switch off
// - fault state shows fault on sense output
// - release needs hold-off low, retry expired, clear
// - thermal fault on absolute or relative excess
// - absolute fault clears after hysteresis drop
// - relative fault clears when retry interval ends
// - overcurrent turns channel off once the deglitch time has passed
// - overcurrent counts only after deglitch time
// - foldback variant halves limit after seven faults
// - standby or clean on-off cycle restores limit
// - plain variant never halves the limit
// - bad limit resistor selects internal limit
// - undervoltage lockout with fall and rise levels
// - surge keeps present switching state
// - retry keeps fault indication until output rises or enable goes low
// - fault drives single high sense level
module hsfc_fault_ctrl
  import hsfc_pkg::*;
#(
  parameter bit FOLDBACK = 1'b1,
  parameter int TW = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire hsfc_pins_s pins,
  output logic switch_on,
  output logic sense_fault,
  output hsfc_lim_e limit_sel,
  output logic irq
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    hsfc_state_e st;       // fault handling state
    logic abs_f;           // absolute over-temperature latched
    logic rel_f;           // relative over-temperature latched
    logic oc_f;            // overcurrent latched
    logic uv;              // undervoltage lockout
    logic [2:0] cnt;       // consecutive fault shutdowns
    logic on_clean;        // switch on with no fault since
    logic [TW-1:0] timer;  // retry interval down counter
    logic [TW-1:0] retry;  // retry interval setting
    logic [3:0] irq_stat;  // sticky events
    logic [3:0] irq_en;    // event enables
    logic [7:0] addr;      // data phase address
    logic wr_pend;         // data phase of a write
    logic switch_on;
    logic sense_fault;
    hsfc_lim_e limit_sel;
    logic irq;
    logic [31:0] hrdata;
    logic hreadyout;
  } hsfc_ctrl_s;

  hsfc_ctrl_s st_ff;
  hsfc_ctrl_s nxt_st;
  hsfc_pins_s pin_s;  // synchronised pin levels
  logic oc_filt;      // deglitched overcurrent

  // ***************************************************************
  // input conditioning
  // ***************************************************************
  // every comparator and pin crosses into clk_sys here
  hsfc_sync #(
    .W($bits(hsfc_pins_s))
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(pins),
    .dout(pin_s)
  );

  // overcurrent spikes shorter than the deglitch time are dropped
  hsfc_deglitch #(
    .CYC(`HSFC_DEGLITCH_CYC)
  ) u_deglitch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .raw(pin_s.oc_over),
    .filt(oc_filt)
  );

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    logic expired;
    logic fault_evt;
    logic release_ok;
    logic [3:0] evt;
    logic [3:0] clr;
    logic addr_ph;
    nxt_st = st_ff;
    fault_evt = 1'b0;
    release_ok = 1'b0;
    expired = (st_ff.timer == '0);
    evt = 4'h0;
    clr = 4'h0;
    addr_ph = hsel && htrans[1] && hready;
    // only active channel can see overcurrent; thermal counts outside hold whether on or off
    fault_evt = (st_ff.st != HSFC_HOLD) &&
                (pin_s.abs_over || pin_s.rel_over || (oc_filt && st_ff.switch_on));
    // undervoltage: fall level locks out, rise level releases
    if (pin_s.supply_fall) begin
      nxt_st.uv = 1'b1;
      evt[`HSFC_IRQ_UV] = !st_ff.uv;
    end else if (pin_s.supply_rise) begin
      nxt_st.uv = 1'b0;
    end
    // absolute flag: set wins, clears only below hysteresis level
    if (pin_s.abs_over) begin
      nxt_st.abs_f = 1'b1;
    end else if (pin_s.below_hys) begin
      nxt_st.abs_f = 1'b0;
    end
    // relative flag clears when the retry interval has run out
    if (pin_s.rel_over) begin
      nxt_st.rel_f = 1'b1;
    end else if (expired && st_ff.st == HSFC_HOLD) begin
      nxt_st.rel_f = 1'b0;
    end
    // overcurrent flag clears with the interval once the level is gone
    if (oc_filt && st_ff.switch_on) begin
      nxt_st.oc_f = 1'b1;
    end else if (expired && !oc_filt && st_ff.st == HSFC_HOLD) begin
      nxt_st.oc_f = 1'b0;
    end
    // retry timer counts down to zero
    if (!expired) begin
      nxt_st.timer = st_ff.timer - TW'(1);
    end
    release_ok = !pin_s.hold_off && expired && !st_ff.abs_f && !st_ff.rel_f && !st_ff.oc_f &&
                 !pin_s.abs_over && !pin_s.rel_over;
    // fault state machine
    case (st_ff.st)
      HSFC_RUN, HSFC_RETRY: begin
        if (fault_evt) begin
          nxt_st.st = HSFC_HOLD;
          nxt_st.timer = st_ff.retry;
          nxt_st.on_clean = 1'b0;
          evt[`HSFC_IRQ_FAULT] = 1'b1;
          if (st_ff.cnt != `HSFC_FOLD_COUNT) begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
            evt[`HSFC_IRQ_FOLD] = FOLDBACK && (st_ff.cnt == `HSFC_FOLD_COUNT - 3'h1);
          end
        end else if (st_ff.st == HSFC_RETRY && (pin_s.vout_high || !pin_s.enable)) begin
          nxt_st.st = HSFC_RUN;
        end
      end
      HSFC_HOLD: begin
        if (release_ok) begin
          // retry only when asked to be on; otherwise back to normal sensing
          nxt_st.st = pin_s.enable ? HSFC_RETRY : HSFC_RUN;
          evt[`HSFC_IRQ_RELEASE] = 1'b1;
        end
      end
      default: begin
        nxt_st.st = HSFC_HOLD;
        nxt_st.timer = st_ff.retry;
      end
    endcase
    // switch drive; a surge freezes the present level, protection still wins
    if (nxt_st.st == HSFC_HOLD || nxt_st.uv) begin
      nxt_st.switch_on = 1'b0;
    end else if (pin_s.surge) begin
      nxt_st.switch_on = st_ff.switch_on;
    end else begin
      nxt_st.switch_on = pin_s.enable;
    end
    nxt_st.sense_fault = (nxt_st.st != HSFC_RUN);
    // foldback count: standby or a clean on-off cycle starts over
    if (nxt_st.switch_on && !st_ff.switch_on) begin
      nxt_st.on_clean = 1'b1;
    end
    if (nxt_st.uv) begin
      nxt_st.cnt = 3'h0;
    end else if (st_ff.on_clean && st_ff.switch_on && !nxt_st.switch_on && nxt_st.st == HSFC_RUN) begin
      nxt_st.cnt = 3'h0;
      nxt_st.on_clean = 1'b0;
    end
    // limit selection; a bad resistor overrides the foldback halving
    if (pin_s.range_bad) begin
      nxt_st.limit_sel = HSFC_LIM_INTERNAL;
    end else if (FOLDBACK && st_ff.cnt == `HSFC_FOLD_COUNT) begin
      nxt_st.limit_sel = HSFC_LIM_HALF;
    end else begin
      nxt_st.limit_sel = HSFC_LIM_FULL;
    end
    // bus write in its data phase
    if (st_ff.wr_pend) begin
      case (st_ff.addr)
        `HSFC_OFS_RETRY: nxt_st.retry = hwdata[TW-1:0];
        `HSFC_OFS_IRQ_CLR: clr = hwdata[3:0];
        `HSFC_OFS_IRQ_EN: nxt_st.irq_en = hwdata[3:0];
        default: begin
        end
      endcase
    end
    // sticky events: a new event beats a clear in the same cycle
    nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | evt;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
    // bus address phase; retry, interrupt status and enable reads use the updated values, status reads the present ones
    nxt_st.wr_pend = addr_ph && hwrite;
    nxt_st.addr = haddr[7:0];
    nxt_st.hrdata = 32'h0;
    nxt_st.hreadyout = 1'b1;
    if (addr_ph && !hwrite && haddr[31:8] == 24'h0) begin
      case (haddr[7:0])
        `HSFC_OFS_RETRY: nxt_st.hrdata[TW-1:0] = nxt_st.retry;
        `HSFC_OFS_STATUS: begin
          nxt_st.hrdata[`HSFC_ST_HOLD] = (st_ff.st == HSFC_HOLD);
          nxt_st.hrdata[`HSFC_ST_RETRY] = (st_ff.st == HSFC_RETRY);
          nxt_st.hrdata[`HSFC_ST_ABS] = st_ff.abs_f;
          nxt_st.hrdata[`HSFC_ST_REL] = st_ff.rel_f;
          nxt_st.hrdata[`HSFC_ST_OC] = st_ff.oc_f;
          nxt_st.hrdata[`HSFC_ST_UV] = st_ff.uv;
          nxt_st.hrdata[`HSFC_ST_SWITCH] = st_ff.switch_on;
          nxt_st.hrdata[`HSFC_ST_SENSE] = st_ff.sense_fault;
          nxt_st.hrdata[`HSFC_ST_CNT_HI:`HSFC_ST_CNT_LO] = st_ff.cnt;
          nxt_st.hrdata[`HSFC_ST_LIM_HI:`HSFC_ST_LIM_LO] = st_ff.limit_sel;
        end
        `HSFC_OFS_IRQ_STAT: nxt_st.hrdata[3:0] = nxt_st.irq_stat;
        `HSFC_OFS_IRQ_EN: nxt_st.hrdata[3:0] = nxt_st.irq_en;
        default: nxt_st.hrdata = 32'h0;  // unmapped and clear register read zero
      endcase
    end
    if (addr_ph && haddr[31:8] != 24'h0) begin
      nxt_st.wr_pend = 1'b0;  // writes outside the map are dropped
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.st <= HSFC_RUN;
      st_ff.retry <= `HSFC_RETRY_RST;
      st_ff.irq_en <= `HSFC_IRQ_EN_RST;
      st_ff.limit_sel <= HSFC_LIM_FULL;
      st_ff.hreadyout <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign switch_on = st_ff.switch_on;
  assign sense_fault = st_ff.sense_fault;
  assign limit_sel = st_ff.limit_sel;
  assign irq = st_ff.irq;
  assign hrdata = st_ff.hrdata;
  assign hreadyout = st_ff.hreadyout;
  assign hresp = 1'b0;  // every transfer answers okay

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_hold_off;
    (st_ff.st == HSFC_HOLD) |-> !switch_on && sense_fault;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("switch on or no fault flag while held off");

  property p_sense_fault;
    (st_ff.st == HSFC_RETRY) |-> sense_fault;
  endproperty
  a_sense_fault: assert property (p_sense_fault) else $error("fault flag dropped during retry");

  property p_hold_pin;
    (st_ff.st == HSFC_HOLD && pin_s.hold_off) |=> (st_ff.st == HSFC_HOLD);
  endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("released while hold-off high");

  property p_abs_keep;
    (st_ff.abs_f && !pin_s.below_hys) |=> st_ff.abs_f;
  endproperty
  a_abs_keep: assert property (p_abs_keep) else $error("absolute fault cleared above hysteresis");

  property p_oc_off;
    (oc_filt && switch_on && st_ff.st != HSFC_HOLD) |=> (st_ff.st == HSFC_HOLD) && !switch_on;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("overcurrent did not switch off");

  property p_fold;
    (st_ff.cnt == `HSFC_FOLD_COUNT && !pin_s.range_bad) |=>
      (limit_sel == (FOLDBACK ? HSFC_LIM_HALF : HSFC_LIM_FULL));
  endproperty
  a_fold: assert property (p_fold) else $error("limit not folded after seven faults");

  property p_range;
    pin_s.range_bad |=> (limit_sel == HSFC_LIM_INTERNAL);
  endproperty
  a_range: assert property (p_range) else $error("bad resistor did not pick internal limit");

  property p_uv;
    st_ff.uv |-> !switch_on;
  endproperty
  a_uv: assert property (p_uv) else $error("switch on under lockout");

  property p_timer;
    (st_ff.st != HSFC_HOLD && nxt_st.st == HSFC_HOLD) |=> (st_ff.timer == $past(st_ff.retry));
  endproperty
  a_timer: assert property (p_timer) else $error("retry timer not loaded at shutdown");

  property p_rel_set;
    pin_s.rel_over |=> st_ff.rel_f ##0 (st_ff.st == HSFC_HOLD);
  endproperty
  a_rel_set: assert property (p_rel_set) else $error("relative fault missed");

  // relative flag must not outlive the retry interval once the excess is gone
  property p_rel_clear;
    (st_ff.rel_f && st_ff.st == HSFC_HOLD && st_ff.timer == '0 && !pin_s.rel_over) |=> !st_ff.rel_f;
  endproperty
  a_rel_clear: assert property (p_rel_clear) else $error("relative fault kept after retry interval");

  // lockout is standby, so the shutdown count is empty throughout
  property p_standby;
    st_ff.uv |-> (st_ff.cnt == 3'h0);
  endproperty
  a_standby: assert property (p_standby) else $error("fault count kept under lockout");

  // a surge may not move the switch unless protection forces it off
  property p_surge;
    (pin_s.surge && nxt_st.st != HSFC_HOLD && !nxt_st.uv) |=> $stable(switch_on);
  endproperty
  a_surge: assert property (p_surge) else $error("switch moved during surge");

endmodule : hsfc_fault_ctrl

// *** core/hsfc_regs.svh ***
// register offsets, field positions, reset values and timing counts of the fault controller
`ifndef HSFC_REGS_SVH
`define HSFC_REGS_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define HSFC_OFS_RETRY 8'h00
`define HSFC_OFS_STATUS 8'h04
`define HSFC_OFS_IRQ_STAT 8'h08
`define HSFC_OFS_IRQ_CLR 8'h0c
`define HSFC_OFS_IRQ_EN 8'h10

// ***************************************************************
// reset values
// ***************************************************************
`define HSFC_RETRY_RST 24'h01e848
`define HSFC_IRQ_EN_RST 4'h0

// ***************************************************************
// interrupt bit positions
// ***************************************************************
`define HSFC_IRQ_FAULT 0
`define HSFC_IRQ_RELEASE 1
`define HSFC_IRQ_FOLD 2
`define HSFC_IRQ_UV 3

// ***************************************************************
// status bit positions
// ***************************************************************
`define HSFC_ST_HOLD 0
`define HSFC_ST_RETRY 1
`define HSFC_ST_ABS 2
`define HSFC_ST_REL 3
`define HSFC_ST_OC 4
`define HSFC_ST_UV 5
`define HSFC_ST_SWITCH 6
`define HSFC_ST_SENSE 7
`define HSFC_ST_CNT_LO 8
`define HSFC_ST_CNT_HI 10
`define HSFC_ST_LIM_LO 12
`define HSFC_ST_LIM_HI 13

// ***************************************************************
// timing
// ***************************************************************
`define HSFC_CLK_PERIOD_NS 8
`define HSFC_DEGLITCH_NS 3000
`define HSFC_DEGLITCH_CYC ((`HSFC_DEGLITCH_NS + `HSFC_CLK_PERIOD_NS - 1) / `HSFC_CLK_PERIOD_NS)
`define HSFC_FOLD_COUNT 3'h7

`endif

// *** core/hsfc_pkg.sv ***
// types shared by the fault controller modules
package hsfc_pkg;

  // fault handling states, one-hot
  typedef enum logic [2:0] {
    HSFC_RUN = 3'h1,
    HSFC_HOLD = 3'h2,
    HSFC_RETRY = 3'h4
  } hsfc_state_e;

  // current limit selection towards the analog limiter
  typedef enum logic [1:0] {
    HSFC_LIM_FULL = 2'h0,
    HSFC_LIM_HALF = 2'h1,
    HSFC_LIM_INTERNAL = 2'h2
  } hsfc_lim_e;

  // comparator and pin levels, all asynchronous to clk_sys
  typedef struct packed {
    logic abs_over;      // fet above absolute_temp_limit
    logic below_hys;     // fet below trip level minus temp_hysteresis
    logic rel_over;      // fet minus controller above relative_temp_limit
    logic oc_over;       // current at overcurrent_threshold
    logic range_bad;     // limit_set_resistor floating, grounded or out of range
    logic supply_fall;   // supply at supply_low_fall_level
    logic supply_rise;   // supply at supply_low_rise_level
    logic vout_high;     // output within 1.8 V of supply
    logic surge;         // suppressed supply surge in progress
    logic enable;        // enable pin
    logic hold_off;      // hold-off pin
  } hsfc_pins_s;

endpackage : hsfc_pkg

// *** core/hsfc_sync.sv ***
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module hsfc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // stage one is read by stage two only
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hsfc_sync_s;

  hsfc_sync_s st_ff;
  hsfc_sync_s nxt_st;

  // shift the levels one stage per edge
  always_comb begin
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  // register the chain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.s2;

endmodule : hsfc_sync

// *** core/hsfc_deglitch.sv ***
// deglitch filter: output rises after the input stayed high for CYC cycles
`timescale 1ns/1ps
module hsfc_deglitch #(
  parameter int CYC = 375
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic raw,
  output logic filt
);

  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;  // cycles the input has been high
    logic filt;          // filtered level
  } hsfc_dg_s;

  hsfc_dg_s st_ff;
  hsfc_dg_s nxt_st;

  // any low cycle restarts the count, so short spikes never pass
  always_comb begin
    nxt_st = st_ff;
    if (!raw) begin
      nxt_st.cnt = '0;
      nxt_st.filt = 1'b0;
    end else if (st_ff.cnt == LAST) begin
      nxt_st.filt = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign filt = st_ff.filt;

endmodule : hsfc_deglitch

// *** testbench/hsfc_mcu_model.sv ***
// behavioural model of the system controller that drives enable and hold-off
`timescale 1ns/1ps
module hsfc_mcu_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic want_on,
  input wire logic want_hold,
  input wire logic supply_ok,
  output logic enable,
  output logic hold_off
);
  // ***************************************************************
  // pin drivers
  // ***************************************************************
  // pins move only after a clock edge; enable waits for a healthy supply
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0;
      hold_off <= 1'b0;
    end else begin
      enable <= want_on & supply_ok;
      hold_off <= want_hold;
    end
  end
endmodule : hsfc_mcu_model

// *** testbench/tb.sv ***
// self-checking testbench of the fault controller
`timescale 1ns/1ps
`include "hsfc_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  import hsfc_pkg::*;
  // ***************************************************************
  // clock, reset, bus and pins
  // ***************************************************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, switch_on, sense_fault, irq;
  logic [31:0] hrdata;
  hsfc_lim_e limit_sel;
  hsfc_pins_s pin_drv; // comparator levels driven by the bench
  hsfc_pins_s pins_w;
  logic want_on = 1'b0;
  logic want_hold = 1'b0;
  logic mcu_en, mcu_hold;
  logic [31:0] rd;
  logic rdy_b; // ready loop of the fixed-limit variant
  hsfc_lim_e lim_fixed; // limit chosen by the fixed-limit variant
  int err_total = 0;
  int n_compared = 0;
  always #4 clk_sys = ~clk_sys;
  // enable and hold-off come from the controller model
  always_comb begin
    pins_w = pin_drv;
    pins_w.enable = mcu_en;
    pins_w.hold_off = mcu_hold;
  end
  hsfc_mcu_model u_mcu (.clk_sys(clk_sys), .rst_n(rst_n), .want_on(want_on), .want_hold(want_hold),
    .supply_ok(~pin_drv.supply_fall), .enable(mcu_en), .hold_off(mcu_hold));
  hsfc_fault_ctrl #(.FOLDBACK(1'b1), .TW(24)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins_w), .switch_on(switch_on),
    .sense_fault(sense_fault), .limit_sel(limit_sel), .irq(irq));
  // fixed-limit variant sees the same bus and pins; only its limit is watched
  hsfc_fault_ctrl #(.FOLDBACK(1'b0), .TW(24)) u_dut_fixed (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy_b),
    .hreadyout(rdy_b), .hresp(), .hrdata(), .pins(pins_w), .switch_on(), .sense_fault(), .limit_sel(lim_fixed),
    .irq());
  // ***************************************************************
  // bus tasks
  // ***************************************************************
  // one single transfer: address phase held until hready, then data phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask : bus
  // wait a bounded time for the switch to reach a level
  task automatic wait_sw(input logic v, input int lim, input string nm);
    int k;
    k = 0;
    while (switch_on !== v && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK(nm, v, switch_on)
  endtask : wait_sw
  // the switch must hold its level for n cycles
  task automatic stay(input logic v, input int n, input string nm);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk_sys);
      if (switch_on !== v) k++;
    end
    `CHK(nm, 0, k)
  endtask : stay
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // ***************************************************************
  // watchdog
  // ***************************************************************
  // whole sequence needs roughly 1000 cycles; a hang ends far later
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    final_report();
  end
  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    pin_drv = '0;
    pin_drv.supply_rise = 1'b1;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // reset values and an unmapped place
    `CHK("switch_rst", 1'b0, switch_on)
    bus(`HSFC_OFS_RETRY, 1'b0, 32'h0);
    `CHK("retry_rst", {8'h00, `HSFC_RETRY_RST}, rd)
    `CHK("hresp", 1'b0, hresp)
    bus(32'h0000_0100, 1'b1, 32'hffff_ffff);
    bus(32'h0000_0100, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    bus(`HSFC_OFS_RETRY, 1'b1, 32'h14);
    bus(`HSFC_OFS_IRQ_EN, 1'b1, 32'hf);
    want_on <= 1'b1;
    wait_sw(1'b1, 10, "switch_up");
    $display("test registers done");
    // absolute over-temperature with hold-off and hysteresis
    pin_drv.abs_over <= 1'b1;
    want_hold <= 1'b1;
    wait_sw(1'b0, 10, "abs_off");
    `CHK("sense_abs", 1'b1, sense_fault)
    pin_drv.abs_over <= 1'b0;
    want_hold <= 1'b0;
    stay(1'b0, 60, "hys_held");
    pin_drv.below_hys <= 1'b1;
    want_hold <= 1'b1;
    stay(1'b0, 60, "hold_held");
    want_hold <= 1'b0;
    wait_sw(1'b1, 10, "released");
    `CHK("sense_retry", 1'b1, sense_fault)
    `CHK("irq_up", 1'b1, irq)
    bus(`HSFC_OFS_IRQ_STAT, 1'b0, 32'h0);
    `CHK("stat_fault", 32'h3, rd)
    bus(`HSFC_OFS_IRQ_EN, 1'b1, 32'h0);
    @(posedge clk_sys);
    `CHK("irq_masked", 1'b0, irq)
    bus(`HSFC_OFS_IRQ_CLR, 1'b1, 32'hf);
    bus(`HSFC_OFS_IRQ_STAT, 1'b0, 32'h0);
    `CHK("stat_clear", 32'h0, rd)
    $display("test thermal done");
    // six relative faults complete seven in a row
    `CHK("lim_full", HSFC_LIM_FULL, limit_sel)
    for (int i = 0; i < 6; i++) begin
      pin_drv.rel_over <= 1'b1;
      wait_sw(1'b0, 10, "rel_off");
      pin_drv.rel_over <= 1'b0;
      stay(1'b0, 10, "timer_run");
      wait_sw(1'b1, 40, "rel_clear");
    end
    @(posedge clk_sys);
    `CHK("lim_half", HSFC_LIM_HALF, limit_sel)
    `CHK("lim_fixed", HSFC_LIM_FULL, lim_fixed)
    $display("test foldback done");
    // short glitch is ignored, a long over-current trips
    pin_drv.oc_over <= 1'b1;
    stay(1'b1, 100, "glitch");
    pin_drv.oc_over <= 1'b0;
    stay(1'b1, 20, "glitch_gone");
    pin_drv.oc_over <= 1'b1;
    wait_sw(1'b0, 400, "oc_off");
    pin_drv.oc_over <= 1'b0;
    wait_sw(1'b1, 40, "oc_retry");
    pin_drv.vout_high <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK("sense_clear", 1'b0, sense_fault)
    $display("test overcurrent done");
    // surge freezes the switch state
    pin_drv.surge <= 1'b1;
    want_on <= 1'b0;
    stay(1'b1, 10, "surge_hold");
    pin_drv.surge <= 1'b0;
    wait_sw(1'b0, 10, "surge_end");
    @(posedge clk_sys);
    `CHK("lim_clean", HSFC_LIM_FULL, limit_sel)
    want_on <= 1'b1;
    wait_sw(1'b1, 10, "on_again");
    // one more fault, left in retry, so that standby has a count to clear
    pin_drv.vout_high <= 1'b0;
    pin_drv.rel_over <= 1'b1;
    wait_sw(1'b0, 10, "rel_again");
    pin_drv.rel_over <= 1'b0;
    wait_sw(1'b1, 40, "rel_back");
    // undervoltage lockout clears the fault count and keeps the full limit
    pin_drv.supply_rise <= 1'b0;
    pin_drv.supply_fall <= 1'b1;
    wait_sw(1'b0, 10, "uv_off");
    @(posedge clk_sys);
    `CHK("lim_restore", HSFC_LIM_FULL, limit_sel)
    bus(`HSFC_OFS_STATUS, 1'b0, 32'h0);
    `CHK("status_uv", 32'h20, rd)
    bus(`HSFC_OFS_IRQ_STAT, 1'b0, 32'h0);
    `CHK("stat_all", 32'hf, rd)
    pin_drv.supply_fall <= 1'b0;
    pin_drv.supply_rise <= 1'b1;
    wait_sw(1'b1, 10, "uv_resume");
    // a bad limit resistor selects the internal limit
    pin_drv.range_bad <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK("lim_internal", HSFC_LIM_INTERNAL, limit_sel)
    pin_drv.range_bad <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK("lim_back", HSFC_LIM_FULL, limit_sel)
    $display("test supply and limit done");
    final_report();
  end
endmodule : tb
